// ===== src/ccf_regs.svh
`ifndef CCF_REGS_SVH
`define CCF_REGS_SVH

// Byte addresses of the software registers on the APB.
`define CCF_ADDR_FLAGS 12'h000
`define CCF_ADDR_CSEL  12'h004
`define CCF_ADDR_CSTAT 12'h008
`define CCF_ADDR_UCNT  12'h00c

// Reset values of the software-visible state.
`define CCF_FLAGS_RST  5'h00
`define CCF_CSEL_RST   4'h0
`define CCF_UCNT_RST   16'h0000

// Widths of the flag and condition-select registers, and the hit bit of the status register.
`define CCF_FLAGS_W    5
`define CCF_CSEL_W     4
`define CCF_CSTAT_HIT  0

// Top bit position of each operand size.
`define CCF_MSB_BYTE   7
`define CCF_MSB_WORD   15
`define CCF_MSB_LONG   31

`endif

// ===== src/ccf_pkg.sv
package ccf_pkg;

   // Width of the source, destination and result buses.
   localparam int DATA_W = 32;

   // Per-flag update policy carried by every operation.
   typedef enum logic [2:0] {
      POL_KEEP  = 3'b000,
      POL_CALC  = 3'b001,
      POL_ZERO  = 3'b010,
      POL_SET   = 3'b011,
      POL_UNDEF = 3'b100
   } ccf_pol_t;

   // How the overflow, carry and zero values are formed.
   typedef enum logic [2:0] {
      CLS_ADD   = 3'b000,
      CLS_SUB   = 3'b001,
      CLS_ADD_X = 3'b010,
      CLS_SUBX  = 3'b011,
      CLS_DEC   = 3'b100,
      CLS_LOGIC = 3'b101,
      CLS_EXT   = 3'b110
   } ccf_cls_t;

   // Operand size.
   typedef enum logic [1:0] {
      SZ_BYTE = 2'b00,
      SZ_WORD = 2'b01,
      SZ_LONG = 2'b10
   } ccf_size_t;

   // Condition codes for branch and set instructions.
   typedef enum logic [3:0] {
      CND_ALWAYS = 4'h0, CND_NEVER  = 4'h1, CND_HIGHER = 4'h2, CND_LOWSAME = 4'h3,
      CND_CARRY0 = 4'h4, CND_CARRY1 = 4'h5, CND_DIFFER = 4'h6, CND_SAME    = 4'h7,
      CND_OVF0   = 4'h8, CND_OVF1   = 4'h9, CND_PLUS   = 4'ha, CND_MINUS   = 4'hb,
      CND_GREQ   = 4'hc, CND_LESS   = 4'hd, CND_GREAT  = 4'he, CND_LESSEQ  = 4'hf
   } ccf_cond_t;

   // The five flags; c lands in bit 0 and x in bit 4.
   typedef struct packed {
      logic x;
      logic n;
      logic z;
      logic v;
      logic c;
   } ccf_flags_t;

   // One operation from the execution datapath.
   typedef struct packed {
      ccf_cls_t            cls;
      ccf_size_t           size;
      ccf_pol_t            pol_x;
      ccf_pol_t            pol_n;
      ccf_pol_t            pol_z;
      ccf_pol_t            pol_v;
      ccf_pol_t            pol_c;
      logic [DATA_W-1:0]   src;
      logic [DATA_W-1:0]   dst;
      logic [DATA_W-1:0]   res;
      logic                v_ext;
      logic                c_ext;
   } ccf_op_t;

endpackage

// ===== src/ccf_cond_eval.sv
`timescale 1ns/1ps

// Evaluates one condition test against the flags.
module ccf_cond_eval (
   input  ccf_pkg::ccf_flags_t flags,
   input  ccf_pkg::ccf_cond_t  code,
   output logic                hit
);

   // Pure logic of the current flags; 1 means the condition is true.
   always_comb begin // [RULE11]
      unique case (code)
         ccf_pkg::CND_ALWAYS:  hit = 1'b1; // [RULE12]
         ccf_pkg::CND_NEVER:   hit = 1'b0;
         ccf_pkg::CND_HIGHER:  hit = ~flags.c & ~flags.z;
         ccf_pkg::CND_LOWSAME: hit = flags.c | flags.z;
         ccf_pkg::CND_CARRY0:  hit = ~flags.c;
         ccf_pkg::CND_CARRY1:  hit = flags.c;
         ccf_pkg::CND_DIFFER:  hit = ~flags.z;
         ccf_pkg::CND_SAME:    hit = flags.z; // [RULE12]
         ccf_pkg::CND_OVF0:    hit = ~flags.v;
         ccf_pkg::CND_OVF1:    hit = flags.v;
         ccf_pkg::CND_PLUS:    hit = ~flags.n;
         ccf_pkg::CND_MINUS:   hit = flags.n;
         ccf_pkg::CND_GREQ:    hit = ~(flags.n ^ flags.v);
         ccf_pkg::CND_LESS:    hit = flags.n ^ flags.v;
         ccf_pkg::CND_GREAT:   hit = ~(flags.n ^ flags.v) & ~flags.z;
         ccf_pkg::CND_LESSEQ:  hit = (flags.n ^ flags.v) | flags.z;
      endcase
   end

endmodule

// ===== src/ccf_flags.sv
// Operation
// (RULE1) Flag store holds negative, zero, overflow, carry, extend.
// (RULE2) Negative follows result top bit at size.
// (RULE3) Zero set only when sized result is zero.
// (RULE4) Overflow set when result is not representable.
// (RULE5) Addition carry set on carry out of top.
// (RULE6) Subtraction carry set when a borrow occurs.
// (RULE7) Moves keep extend; arithmetic copies carry to extend.
// (RULE8) Apply each flag's own update policy.
// (RULE9) Affected flags update on every execution.
// (RULE10) Logic-type ops keep extend, clear overflow, carry.
// (RULE11) Conditions are logic functions of current flags.
// (RULE12) Always-true succeeds; same-value needs zero set.
// (RULE13) Add overflow and carry from top bits.
// (RULE14) Extended ops only clear zero, never set it.
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "ccf_regs.svh"

module ccf_flags #(
   parameter int CNT_W = 16
) (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                op_valid,
   input  ccf_pkg::ccf_op_t         op,
   input  ccf_pkg::ccf_cond_t       cond_code,
   output logic                     cond_true,
   output ccf_pkg::ccf_flags_t      flags_out
);

   // Returns the top bit of a value at the given operand size.
   function automatic logic top_bit(input ccf_pkg::ccf_size_t sz,
                                    input logic [ccf_pkg::DATA_W-1:0] val);
      logic b;
      b = val[`CCF_MSB_LONG];
      if (sz == ccf_pkg::SZ_BYTE) begin
         b = val[`CCF_MSB_BYTE];
      end else if (sz == ccf_pkg::SZ_WORD) begin
         b = val[`CCF_MSB_WORD];
      end
      return b;
   endfunction

   // Returns one when the value is all zeros at the given operand size.
   function automatic logic all_zero(input ccf_pkg::ccf_size_t sz,
                                     input logic [ccf_pkg::DATA_W-1:0] val);
      logic z;
      z = (val == '0);
      if (sz == ccf_pkg::SZ_BYTE) begin
         z = (val[`CCF_MSB_BYTE:0] == '0);
      end else if (sz == ccf_pkg::SZ_WORD) begin
         z = (val[`CCF_MSB_WORD:0] == '0);
      end
      return z;
   endfunction

   // Applies one flag's policy; an undefined result keeps the old value.
   function automatic logic apply_pol(input ccf_pkg::ccf_pol_t pol,
                                      input logic old_v,
                                      input logic calc_v);
      logic r;
      unique case (pol)
         ccf_pkg::POL_KEEP:  r = old_v;
         ccf_pkg::POL_CALC:  r = calc_v;
         ccf_pkg::POL_ZERO:  r = 1'b0;
         ccf_pkg::POL_SET:   r = 1'b1;
         ccf_pkg::POL_UNDEF: r = old_v;
         default:            r = old_v; // Codes above undefined are illegal.
      endcase
      return r;
   endfunction

   ccf_pkg::ccf_flags_t   flags_ff;     // The flag store.
   ccf_pkg::ccf_flags_t   nxt_flags;    // Flags after the current operation.
   logic [`CCF_CSEL_W-1:0] csel_ff;     // Condition chosen by software.
   logic [CNT_W-1:0]      ucnt_ff;      // Count of flag updates.
   logic [31:0]           prdata_ff;    // Read data, loaded in setup phase.
   logic                  s_m;          // Source top bit.
   logic                  d_m;          // Destination top bit.
   logic                  r_m;          // Result top bit.
   logic                  r_zero;       // Sized result is zero.
   logic                  add_v;        // Addition overflow.
   logic                  add_c;        // Addition carry.
   logic                  sub_v;        // Subtraction overflow.
   logic                  sub_c;        // Subtraction borrow.
   logic                  calc_z;       // Zero value by class.
   logic                  calc_v;       // Overflow value by class.
   logic                  calc_c;       // Carry value by class.
   logic                  is_logic;     // Data movement class.
   logic                  sw_hit;       // Outcome of the software condition.
   logic                  apb_setup;    // Setup phase of a transfer.
   logic                  apb_wr;       // Write access phase.
   logic                  addr_hit;     // Address maps to a register.
   logic [31:0]           rd_mux;       // Read value for the current address.

   // Top bits and zero detect, all at the operation's size.
   assign s_m    = top_bit(op.size, op.src);
   assign d_m    = top_bit(op.size, op.dst);
   assign r_m    = top_bit(op.size, op.res); // [RULE2]
   assign r_zero = all_zero(op.size, op.res); // [RULE3]

   // Signed overflow of an addition: like signs in, other sign out.
   assign add_v = (s_m & d_m & ~r_m) | (~s_m & ~d_m & r_m); // [RULE13] [RULE4]
   // Carry out of the top bit of an addition.
   assign add_c = (s_m & d_m) | (~r_m & d_m) | (s_m & ~r_m); // [RULE13] [RULE5]
   // Signed overflow of destination minus source.
   assign sub_v = (~s_m & d_m & ~r_m) | (s_m & ~d_m & r_m); // [RULE4]
   // Borrow out of destination minus source.
   assign sub_c = (s_m & ~d_m) | (r_m & ~d_m) | (s_m & r_m); // [RULE6]

   assign is_logic = (op.cls == ccf_pkg::CLS_LOGIC);

   // Class-dependent values of zero, overflow and carry.
   always_comb begin
      calc_z = r_zero; // [RULE3]
      calc_v = 1'b0;
      calc_c = 1'b0;
      unique case (op.cls)
         ccf_pkg::CLS_ADD: begin
            calc_v = add_v;
            calc_c = add_c;
         end
         ccf_pkg::CLS_SUB: begin
            calc_v = sub_v;
            calc_c = sub_c;
         end
         ccf_pkg::CLS_ADD_X: begin
            // Zero only ever clears so it spans a multiword chain.
            calc_z = r_zero ? flags_ff.z : 1'b0; // [RULE14]
            calc_v = add_v;
            calc_c = add_c;
         end
         ccf_pkg::CLS_SUBX: begin
            calc_z = r_zero ? flags_ff.z : 1'b0; // [RULE14]
            calc_v = sub_v;
            calc_c = sub_c;
         end
         ccf_pkg::CLS_DEC: begin
            // The decimal adjuster supplies carry or borrow itself.
            calc_z = r_zero ? flags_ff.z : 1'b0; // [RULE14]
            calc_v = op.v_ext;
            calc_c = op.c_ext;
         end
         ccf_pkg::CLS_LOGIC: begin
            calc_v = 1'b0; // [RULE10]
            calc_c = 1'b0; // [RULE10]
         end
         ccf_pkg::CLS_EXT: begin
            // Divide and multiply report their own overflow.
            calc_v = op.v_ext; // [RULE4]
            calc_c = op.c_ext;
         end
         default: begin
            // The unused class code takes every computed value from the stored flag.
            calc_z = flags_ff.z;
            calc_v = flags_ff.v;
            calc_c = flags_ff.c;
         end
      endcase
   end

   // Per-flag policy; extend takes the carry value, never moves on logic ops.
   always_comb begin
      nxt_flags.n = apply_pol(op.pol_n, flags_ff.n, r_m); // [RULE8] [RULE2]
      nxt_flags.z = apply_pol(op.pol_z, flags_ff.z, calc_z); // [RULE8]
      nxt_flags.v = apply_pol(op.pol_v, flags_ff.v, calc_v); // [RULE8]
      nxt_flags.c = apply_pol(op.pol_c, flags_ff.c, calc_c); // [RULE8]
      nxt_flags.x = is_logic ? flags_ff.x // [RULE7] [RULE10]
                             : apply_pol(op.pol_x, flags_ff.x, calc_c); // [RULE7]
   end

   assign apb_setup = psel & ~penable;
   assign apb_wr    = psel & penable & pwrite;

   // Address decode; anything else answers with an error.
   assign addr_hit = (paddr == `CCF_ADDR_FLAGS) | (paddr == `CCF_ADDR_CSEL) |
                     (paddr == `CCF_ADDR_CSTAT) | (paddr == `CCF_ADDR_UCNT);

   // The flag store. An operation beats a software write in the same cycle,
   // so the processor never loses a result to a racing register write.
   always_ff @(posedge pclk or negedge presetn) begin // [RULE1]
      if (!presetn) begin
         flags_ff <= `CCF_FLAGS_RST;
      end else if (op_valid) begin
         flags_ff <= nxt_flags; // [RULE9]
      end else if (apb_wr && paddr == `CCF_ADDR_FLAGS) begin
         flags_ff <= pwdata[`CCF_FLAGS_W-1:0];
      end
   end

   // Condition chosen for the software test.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         csel_ff <= `CCF_CSEL_RST;
      end else if (apb_wr && paddr == `CCF_ADDR_CSEL) begin
         csel_ff <= pwdata[`CCF_CSEL_W-1:0];
      end
   end

   // Update counter; it wraps, so software should take differences.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ucnt_ff <= CNT_W'(`CCF_UCNT_RST);
      end else if (op_valid) begin
         ucnt_ff <= ucnt_ff + CNT_W'(1);
      end
   end

   // Read value of the addressed register; unused bits read as zero.
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (paddr == `CCF_ADDR_FLAGS) begin
         rd_mux = 32'(flags_ff);
      end else if (paddr == `CCF_ADDR_CSEL) begin
         rd_mux = 32'(csel_ff);
      end else if (paddr == `CCF_ADDR_CSTAT) begin
         rd_mux[`CCF_CSTAT_HIT] = sw_hit;
      end else if (paddr == `CCF_ADDR_UCNT) begin
         rd_mux = 32'(ucnt_ff);
      end
   end

   // Read data is captured at the setup edge so it comes from a flop.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h0000_0000;
      end else if (apb_setup && !pwrite) begin
         prdata_ff <= rd_mux;
      end
   end

   assign prdata    = prdata_ff;
   assign pready    = 1'b1;
   assign pslverr   = psel & penable & ~addr_hit;
   assign flags_out = flags_ff;

   // Condition seen by the instruction sequencer.
   ccf_cond_eval u_seq_eval (
      .flags (flags_ff),
      .code  (cond_code),
      .hit   (cond_true)
   );

   // Condition seen by software through the status register.
   ccf_cond_eval u_sw_eval (
      .flags (flags_ff),
      .code  (ccf_pkg::ccf_cond_t'(csel_ff)),
      .hit   (sw_hit)
   );

   // Checks on the flag behaviour.
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_upd(ccf_pkg::ccf_cls_t k);
      op_valid && op.cls == k;
   endsequence

   sequence s_idle;
      !op_valid && !(apb_wr && paddr == `CCF_ADDR_FLAGS);
   endsequence

   AST_N_TOP: assert property ( // [RULE2]
      op_valid && op.pol_n == ccf_pkg::POL_CALC |=> flags_ff.n == $past(r_m))
      else $error("Negative flag does not follow the result top bit.");

   AST_Z_PLAIN: assert property ( // [RULE3]
      s_upd(ccf_pkg::CLS_ADD) and (op.pol_z == ccf_pkg::POL_CALC)
      |=> flags_ff.z == $past(r_zero))
      else $error("Zero flag does not match the sized result.");

   AST_ADD_VC: assert property ( // [RULE13]
      s_upd(ccf_pkg::CLS_ADD) and (op.pol_v == ccf_pkg::POL_CALC)
      and (op.pol_c == ccf_pkg::POL_CALC)
      |=> flags_ff.v == $past(add_v) && flags_ff.c == $past(add_c))
      else $error("Addition overflow or carry is wrong.");

   AST_SUB_C: assert property ( // [RULE6]
      s_upd(ccf_pkg::CLS_SUB) and (op.pol_c == ccf_pkg::POL_CALC)
      |=> flags_ff.c == $past(sub_c))
      else $error("Subtraction borrow is wrong.");

   AST_X_COPY: assert property ( // [RULE7]
      op_valid && !is_logic && op.pol_x == ccf_pkg::POL_CALC
      && op.pol_c == ccf_pkg::POL_CALC |=> flags_ff.x == flags_ff.c)
      else $error("Extend flag differs from carry.");

   AST_LOGIC: assert property ( // [RULE10]
      s_upd(ccf_pkg::CLS_LOGIC) and (op.pol_v == ccf_pkg::POL_CALC)
      and (op.pol_c == ccf_pkg::POL_CALC)
      |=> $stable(flags_ff.x) && !flags_ff.v && !flags_ff.c)
      else $error("Logic operation changed extend or left overflow or carry.");

   AST_FORCE: assert property ( // [RULE8]
      op_valid && op.pol_v == ccf_pkg::POL_SET && op.pol_c == ccf_pkg::POL_ZERO
      |=> flags_ff.v && !flags_ff.c)
      else $error("Forced flag values not applied.");

   AST_Z_ACCUM: assert property ( // [RULE14]
      s_upd(ccf_pkg::CLS_ADD_X) and (op.pol_z == ccf_pkg::POL_CALC)
      |=> flags_ff.z == ($past(flags_ff.z) && $past(r_zero)))
      else $error("Extended zero flag did not accumulate.");

   AST_HOLD: assert property ( // [RULE9]
      s_idle ##1 s_idle |=> $stable(flags_ff))
      else $error("Flags changed without an update.");

   AST_SAME: assert property ( // [RULE12]
      cond_code == ccf_pkg::CND_SAME |-> cond_true == flags_ff.z)
      else $error("Same-value condition disagrees with zero flag.");

endmodule

// ===== bench/ccf_dp_model.sv
`timescale 1ns/1ps

// Stands in for the execution datapath. It issues one queued operation per
// cycle as a one-cycle op_valid pulse, back to back while several wait.
module ccf_dp_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   output logic             op_valid,
   output ccf_pkg::ccf_op_t op
);
   // Operations waiting to issue, filled by the bench.
   ccf_pkg::ccf_op_t q[$];

   // Quiet bus at time zero.
   initial begin
      op_valid = 1'b0;
      op       = '0;
   end

   // On every cycle without a pulse the operand bus is inverted, so a stale value
   // toggles rather than staying steady as if it were still held.
   always @(posedge pclk) begin
      if (presetn && q.size() != 0) begin
         op_valid <= 1'b1;
         op       <= q.pop_front();
      end else begin
         op_valid <= 1'b0;
         op       <= ccf_pkg::ccf_op_t'(~op);
      end
   end
endmodule

// ===== bench/tb.sv
`timescale 1ns/1ps
`include "ccf_regs.svh"

module tb;
   logic                pclk, presetn, psel, penable, pwrite;
   logic                pready, pslverr, op_valid, cond_true;
   logic [11:0]         paddr;
   logic [31:0]         pwdata, prdata;
   ccf_pkg::ccf_op_t    op;
   ccf_pkg::ccf_cond_t  cond_code;
   ccf_pkg::ccf_flags_t flags_out;
   int                  errors, num_checks;
   ccf_pkg::ccf_op_t    ox;          // Operation that drives the external flag inputs.

   // Policy shorthands; a policy vector is {x, n, z, v, c}.
   localparam logic [2:0]  p_keep = ccf_pkg::POL_KEEP;
   localparam logic [2:0]  p_calc = ccf_pkg::POL_CALC;
   localparam logic [2:0]  p_zero = ccf_pkg::POL_ZERO;
   localparam logic [2:0]  p_set  = ccf_pkg::POL_SET;
   localparam logic [2:0]  p_und  = ccf_pkg::POL_UNDEF;
   localparam logic [14:0] all_c  = {5{p_calc}};

   ccf_flags #(.CNT_W(16)) i_ccf_flags (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .op_valid(op_valid), .op(op),
      .cond_code(cond_code), .cond_true(cond_true), .flags_out(flags_out));

   ccf_dp_model i_ccf_dp_model (.pclk(pclk), .presetn(presetn), .op_valid(op_valid), .op(op));

   // Free-running 100 MHz clock.
   initial pclk = 1'b0;
   always #5 pclk = ~pclk;

   // Compares one value and counts it.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Prints the verdict and ends the run.
   task automatic stop_test();
      if (errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // One APB transfer, then one idle edge so calls may follow directly.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) errors++;
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      paddr   <= ~a;
      pwdata  <= ~d;
      @(posedge pclk);
   endtask

   // Register write.
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask

   // Register read with expected data and expected error response.
   task automatic rdc(input logic [11:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      chk(q, x);
      chk({31'h0, e}, {31'h0, xe});
   endtask

   // Builds an operation; the external overflow and carry inputs stay low.
   function automatic ccf_pkg::ccf_op_t mk(ccf_pkg::ccf_cls_t c, ccf_pkg::ccf_size_t s,
      logic [14:0] p, logic [31:0] sr, logic [31:0] ds, logic [31:0] rs);
      return ccf_pkg::ccf_op_t'({c, s, p, sr, ds, rs, 2'b00});
   endfunction

   // Queues operations and waits until the last one has landed.
   task automatic run(input ccf_pkg::ccf_op_t o, input int cnt);
      int n;
      for (int i = 0; i < cnt; i++) i_ccf_dp_model.q.push_back(o);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (i_ccf_dp_model.q.size() != 0 && n < 50);
      if (n >= 50) errors++;
      repeat (2) @(posedge pclk);
   endtask

   // Compares the flag outputs, {x, n, z, v, c}.
   task automatic chf(input logic [4:0] x);
      chk({27'h0, flags_out}, {27'h0, x});
   endtask

   // Reference outcome of each condition test.
   function automatic logic cexp(ccf_pkg::ccf_flags_t f, logic [3:0] k);
      case (k)
         4'h0: return 1'b1;
         4'h1: return 1'b0;
         4'h2: return ~f.c & ~f.z;
         4'h3: return f.c | f.z;
         4'h4: return ~f.c;
         4'h5: return f.c;
         4'h6: return ~f.z;
         4'h7: return f.z;
         4'h8: return ~f.v;
         4'h9: return f.v;
         4'ha: return ~f.n;
         4'hb: return f.n;
         4'hc: return f.n == f.v;
         4'hd: return f.n != f.v;
         4'he: return (f.n == f.v) & ~f.z;
         default: return (f.n != f.v) | f.z;
      endcase
   endfunction

   // Main sequence.
   initial begin
      presetn   = 1'b0;
      psel      = 1'b0;
      penable   = 1'b0;
      pwrite    = 1'b0;
      paddr     = 12'h0;
      pwdata    = 32'h0;
      cond_code = ccf_pkg::CND_ALWAYS;
      errors     = 0;
      num_checks = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chf(5'h00);
      rdc(`CCF_ADDR_FLAGS, 32'h0, 1'b0);
      wr(`CCF_ADDR_FLAGS, 32'hffff_ffff);
      rdc(`CCF_ADDR_FLAGS, 32'h1f, 1'b0);
      rdc(12'h010, 32'h0, 1'b1);
      rdc(`CCF_ADDR_UCNT, 32'h0, 1'b0);
      // Byte and word adds whose upper operand and result bits must be ignored.
      run(mk(ccf_pkg::CLS_ADD, ccf_pkg::SZ_BYTE, all_c, 32'h7f, 32'hffff_ff01, 32'h80), 1);
      chf(5'h0a);
      run(mk(ccf_pkg::CLS_ADD, ccf_pkg::SZ_BYTE, all_c, 32'hff, 32'h01, 32'h1234_5600), 1);
      chf(5'h15);
      run(mk(ccf_pkg::CLS_ADD, ccf_pkg::SZ_WORD, all_c, 32'h8000, 32'h8000, 32'h1_0000), 1);
      chf(5'h17);
      run(mk(ccf_pkg::CLS_LOGIC, ccf_pkg::SZ_LONG, all_c, 32'h1, 32'h1, 32'h0), 1);
      chf(5'h14);
      run(mk(ccf_pkg::CLS_SUB, ccf_pkg::SZ_LONG, all_c, 32'h1, 32'h0, 32'hffff_ffff), 1);
      chf(5'h19);
      // Every policy code other than calculate; in the first operation the calculated values would disagree for all but keep.
      run(mk(ccf_pkg::CLS_ADD, ccf_pkg::SZ_LONG, {p_set, p_zero, p_keep, p_und, p_set},
             32'h0, 32'h0, 32'h8000_0000), 1);
      chf(5'h11);
      run(mk(ccf_pkg::CLS_ADD, ccf_pkg::SZ_LONG, {p_zero, p_set, p_set, p_set, p_zero},
             32'h0, 32'h0, 32'h1), 1);
      chf(5'h0e);
      // Extended add: zero may only be cleared, so it accumulates.
      wr(`CCF_ADDR_FLAGS, 32'h04);
      run(mk(ccf_pkg::CLS_ADD_X, ccf_pkg::SZ_LONG, all_c, 32'h0, 32'h0, 32'h0), 1);
      chf(5'h04);
      run(mk(ccf_pkg::CLS_ADD_X, ccf_pkg::SZ_LONG, all_c, 32'h0, 32'h0, 32'h1), 1);
      chf(5'h00);
      run(mk(ccf_pkg::CLS_ADD_X, ccf_pkg::SZ_LONG, all_c, 32'h0, 32'h0, 32'h0), 1);
      chf(5'h00);
      // Three back-to-back executions each update and each count.
      run(mk(ccf_pkg::CLS_ADD, ccf_pkg::SZ_BYTE, all_c, 32'h7f, 32'h01, 32'h80), 3);
      chf(5'h0a);
      rdc(`CCF_ADDR_UCNT, 32'h0000_000d, 1'b0);
      // Extended subtract borrows; the zero flag was already clear and stays so.
      run(mk(ccf_pkg::CLS_SUBX, ccf_pkg::SZ_LONG, all_c, 32'h1, 32'h0, 32'hffff_ffff), 1);
      chf(5'h19);
      // Decimal step with its own carry; zero survives a zero byte result.
      wr(`CCF_ADDR_FLAGS, 32'h04);
      ox = mk(ccf_pkg::CLS_DEC, ccf_pkg::SZ_BYTE, all_c, 32'h0, 32'h0, 32'h100);
      ox.c_ext = 1'b1;
      run(ox, 1);
      chf(5'h15);
      // Multiply or divide reports its own overflow.
      ox = mk(ccf_pkg::CLS_EXT, ccf_pkg::SZ_LONG, all_c, 32'h0, 32'h0, 32'h5);
      ox.v_ext = 1'b1;
      run(ox, 1);
      chf(5'h02);
      // Every condition code against every flag pattern.
      for (int f = 0; f < 32; f++) begin
         wr(`CCF_ADDR_FLAGS, f);
         for (int k = 0; k < 16; k++) begin
            cond_code <= ccf_pkg::ccf_cond_t'(k[3:0]);
            @(posedge pclk);
            chk({31'h0, cond_true}, {31'h0, cexp(f[4:0], k[3:0])});
         end
      end
      // Every condition code seen through the software status register, with only zero set.
      wr(`CCF_ADDR_FLAGS, 32'h04);
      for (int k = 0; k < 16; k++) begin
         wr(`CCF_ADDR_CSEL, k);
         rdc(`CCF_ADDR_CSTAT, {31'h0, cexp(5'h04, k[3:0])}, 1'b0);
      end
      stop_test();
   end

   // Watchdog: the sequence needs some 800 cycles, so 10,000 means a hang.
   initial begin
      #100_000;
      errors++;
      stop_test();
   end
endmodule
